// File: core/scb_bank.sv
// module: serial-loaded configuration register bank
//
// How it works
// - select code 000 updates the integer/fraction word.
// - select code 001 updates the low-fraction word.
// - select code 010 updates the reference-divider word.
// - integer/fraction bit 31 enables frequency ramping when one.
// - integer/fraction bits 30..27 pick the test output selector source.
// - a 12-bit field supplies the integer division factor.
// - numerator upper 12 bits come from integer/fraction bits 14..3.
// - numerator lower 13 bits come from low-fraction bits 27..15.
// - numerator equals low part plus upper part shifted left thirteen.
// - slip-reduction enable bit one turns on cycle slip reduction.
// - 32-bit words shift in msb first, one bit per serial rising edge.
// - load strobe rising edge copies shift register into selected latch.
// - double-buffered settings apply only after a later integer/fraction write.
`timescale 1ns/1ps
`default_nettype none
module scb_bank (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    output var scb_pkg::scb_settings_s settings,
    output logic [31:0] word_out [8]
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic clk_q;
    logic le_q;
    logic [31:0] shift_reg;
    logic [31:0] latch [8];
    logic [11:0] fine_divide_numerator_hi_act;
    logic [12:0] fine_divide_numerator_lo_act;
    logic [3:0] cp_act;
    logic halve_act;
    logic doubler_act;
    logic [4:0] rcnt_act;
    logic clk_rise;
    logic le_rise;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {load_strobe, serial_data, serial_clk};
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_q <= 1'b0;
            le_q <= 1'b0;
        end else begin
            clk_q <= sync_b[0];
            le_q <= sync_b[2];
        end
    end

    assign clk_rise = sync_b[0] & ~clk_q;
    assign le_rise = sync_b[2] & ~le_q;

    // ----------------------------------------
    // shift register
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            shift_reg <= scb_pkg::WORD_RST;
        end else if (clk_rise) begin
            shift_reg <= {shift_reg[30:0], sync_b[1]};
        end
    end

    // ----------------------------------------
    // latches, one per select code
    // ----------------------------------------
    for (genvar i = 0; i < scb_pkg::NUM_REGS; i++) begin : g_latch
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                latch[i] <= scb_pkg::WORD_RST;
            end else if (le_rise && shift_reg[2:0] == 3'(i)) begin
                latch[i] <= shift_reg;
            end
        end
        assign word_out[i] = latch[i];
    end

    // ----------------------------------------
    // double-buffered settings
    // ----------------------------------------
    // applied when the integer/fraction word is loaded, using the already latched others
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fine_divide_numerator_hi_act <= 12'h000;
            fine_divide_numerator_lo_act <= 13'h0000;
            cp_act <= 4'h0;
            halve_act <= 1'b0;
            doubler_act <= 1'b0;
            rcnt_act <= 5'h00;
        end else if (le_rise && shift_reg[2:0] == scb_pkg::SEL_INT_FINE_DIVIDE_NUMERATOR) begin
            fine_divide_numerator_hi_act <= shift_reg[scb_pkg::FINE_DIVIDE_NUMERATOR_HI_MSB:scb_pkg::FINE_DIVIDE_NUMERATOR_HI_LSB];
            fine_divide_numerator_lo_act <= latch[1][scb_pkg::FINE_DIVIDE_NUMERATOR_LO_MSB:scb_pkg::FINE_DIVIDE_NUMERATOR_LO_LSB];
            cp_act <= latch[2][scb_pkg::CP_MSB:scb_pkg::CP_LSB];
            halve_act <= latch[2][scb_pkg::HALVE_BIT];
            doubler_act <= latch[2][scb_pkg::DOUBLER_BIT];
            rcnt_act <= latch[2][scb_pkg::RCNT_MSB:scb_pkg::RCNT_LSB];
        end
    end

    // ----------------------------------------
    // settings output
    // ----------------------------------------
    always_comb begin
        settings.ramp_enable = latch[0][scb_pkg::RAMP_ON_BIT];
        settings.test_output_selector = latch[0][scb_pkg::MUX_MSB:scb_pkg::MUX_LSB];
        settings.integer_value = latch[0][scb_pkg::INT_MSB:scb_pkg::INT_LSB];
        settings.fine_divide_numerator = {12'h000, fine_divide_numerator_lo_act} + (25'(fine_divide_numerator_hi_act) << scb_pkg::FINE_DIVIDE_NUMERATOR_LO_W);
        settings.slip_reduction_enable = latch[2][scb_pkg::SLIP_EN_BIT];
        settings.charge_pump_current = cp_act;
        settings.reference_halving = halve_act;
        settings.reference_doubler = doubler_act;
        settings.reference_count = rcnt_act;
        settings.detector_sign_select = latch[3][scb_pkg::DET_SIGN_BIT];
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_shift_in;
        @(posedge core_clk) disable iff (sys_rst)
        clk_rise |=> shift_reg[0] == $past(sync_b[1]) && shift_reg[31:1] == $past(shift_reg[30:0]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift register did not take one bit");

    property p_shift_hold;
        @(posedge core_clk) disable iff (sys_rst)
        !clk_rise |=> $stable(shift_reg);
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shift register moved without a link clock edge");

    property p_func_load;
        @(posedge core_clk) disable iff (sys_rst)
        (le_rise && shift_reg[2:0] == 3'h3) |=> word_out[3] == $past(shift_reg)
            && settings.detector_sign_select == $past(shift_reg[6]);
    endproperty
    a_func_load: assert property (p_func_load) else $error("function word not loaded");

    property p_int_load;
        @(posedge core_clk) disable iff (sys_rst)
        (le_rise && shift_reg[2:0] == 3'h0) |=> word_out[0] == $past(shift_reg);
    endproperty
    a_int_load: assert property (p_int_load) else $error("integer word not loaded");

    property p_low_load;
        @(posedge core_clk) disable iff (sys_rst)
        (le_rise && shift_reg[2:0] == 3'h1) |=> word_out[1] == $past(shift_reg);
    endproperty
    a_low_load: assert property (p_low_load) else $error("low fraction word not loaded");

    property p_ref_load;
        @(posedge core_clk) disable iff (sys_rst)
        (le_rise && shift_reg[2:0] == 3'h2) |=> word_out[2] == $past(shift_reg);
    endproperty
    a_ref_load: assert property (p_ref_load) else $error("reference word not loaded");

    property p_hold;
        @(posedge core_clk) disable iff (sys_rst)
        !(le_rise && shift_reg[2:0] == 3'h0) |=> $stable(word_out[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("integer word changed without its code");

    property p_hold_low;
        @(posedge core_clk) disable iff (sys_rst)
        !(le_rise && shift_reg[2:0] == 3'h1) |=> $stable(word_out[1]);
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("low fraction word changed without its code");

    property p_ramp;
        @(posedge core_clk) disable iff (sys_rst)
        settings.ramp_enable == word_out[0][31];
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp enable wrong bit");

    property p_mux;
        @(posedge core_clk) disable iff (sys_rst)
        (le_rise && shift_reg[2:0] == 3'h0) |=> settings.test_output_selector == $past(shift_reg[30:27])
            && settings.integer_value == $past(shift_reg[26:15]);
    endproperty
    a_mux: assert property (p_mux) else $error("selector or integer field wrong");

    property p_numerator;
        @(posedge core_clk) disable iff (sys_rst)
        (le_rise && shift_reg[2:0] == 3'h0) |=>
            settings.fine_divide_numerator == {$past(shift_reg[14:3]), $past(word_out[1][27:15])};
    endproperty
    a_numerator: assert property (p_numerator) else $error("numerator assembly wrong");

    property p_dbuf;
        @(posedge core_clk) disable iff (sys_rst)
        !(le_rise && shift_reg[2:0] == 3'h0) |=> $stable(settings.reference_count) && $stable(fine_divide_numerator_lo_act);
    endproperty
    a_dbuf: assert property (p_dbuf) else $error("buffered setting changed early");

    property p_dbuf_ref;
        @(posedge core_clk) disable iff (sys_rst)
        !(le_rise && shift_reg[2:0] == 3'h0) |=> $stable(settings.charge_pump_current)
            && $stable(settings.reference_halving) && $stable(settings.reference_doubler)
            && $stable(settings.fine_divide_numerator);
    endproperty
    a_dbuf_ref: assert property (p_dbuf_ref) else $error("buffered reference setting changed early");

    property p_dbuf_take;
        @(posedge core_clk) disable iff (sys_rst)
        (le_rise && shift_reg[2:0] == 3'h0) |=> settings.reference_count == $past(word_out[2][19:15])
            && settings.charge_pump_current == $past(word_out[2][27:24]);
    endproperty
    a_dbuf_take: assert property (p_dbuf_take) else $error("buffered reference setting not taken");

    property p_slip;
        @(posedge core_clk) disable iff (sys_rst)
        settings.slip_reduction_enable == word_out[2][28];
    endproperty
    a_slip: assert property (p_slip) else $error("slip enable wrong bit");
endmodule
`default_nettype wire

// File: core/scb_pkg.sv
// package: constants and carriers for the synthesizer configuration register bank
package scb_pkg;
    localparam int WORD_W = 32;
    localparam int SEL_W = 3;
    // select codes
    localparam logic [2:0] SEL_INT_FINE_DIVIDE_NUMERATOR = 3'h0;
    localparam logic [2:0] SEL_LOW_FINE_DIVIDE_NUMERATOR = 3'h1;
    localparam logic [2:0] SEL_REF_DIV = 3'h2;
    localparam logic [2:0] SEL_FUNCTION = 3'h3;
    localparam logic [2:0] SEL_TEST = 3'h4;
    localparam logic [2:0] SEL_DEVIATION = 3'h5;
    localparam logic [2:0] SEL_STEP = 3'h6;
    localparam logic [2:0] SEL_DELAY = 3'h7;
    localparam int NUM_REGS = 8;
    // field positions
    localparam int RAMP_ON_BIT = 31;
    localparam int MUX_MSB = 30;
    localparam int MUX_LSB = 27;
    localparam int INT_MSB = 26;
    localparam int INT_LSB = 15;
    localparam int FINE_DIVIDE_NUMERATOR_HI_MSB = 14;
    localparam int FINE_DIVIDE_NUMERATOR_HI_LSB = 3;
    localparam int FINE_DIVIDE_NUMERATOR_LO_MSB = 27;
    localparam int FINE_DIVIDE_NUMERATOR_LO_LSB = 15;
    localparam int FINE_DIVIDE_NUMERATOR_LO_W = 13;
    localparam int SLIP_EN_BIT = 28;
    localparam int CP_MSB = 27;
    localparam int CP_LSB = 24;
    localparam int HALVE_BIT = 21;
    localparam int DOUBLER_BIT = 20;
    localparam int RCNT_MSB = 19;
    localparam int RCNT_LSB = 15;
    localparam int DET_SIGN_BIT = 6;
    // reset value; none is documented for the latches
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    typedef struct packed {
        logic ramp_enable;
        logic [3:0] test_output_selector;
        logic [11:0] integer_value;
        logic [24:0] fine_divide_numerator;
        logic slip_reduction_enable;
        logic [3:0] charge_pump_current;
        logic reference_halving;
        logic reference_doubler;
        logic [4:0] reference_count;
        logic detector_sign_select;
    } scb_settings_s;
endpackage

// File: verif/scb_host.sv
// host model driving the three-wire programming link of the register bank
`timescale 1ns/1ps
`default_nettype none
module scb_host (
    input wire logic core_clk,
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    // half period of the link clock in core cycles, 80 ns
    localparam int HALF = 8;
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    // callers enter at a falling core edge; the link clock stays low between frames
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            serial_data = w[i];
            repeat (HALF) @(negedge core_clk);
            serial_clk = 1'b1;
            repeat (HALF) @(negedge core_clk);
            serial_clk = 1'b0;
        end
        // data line released: show the inverse of the last bit
        serial_data = ~serial_data;
        repeat (HALF) @(negedge core_clk);
        load_strobe = 1'b1;
        repeat (HALF) @(negedge core_clk);
        load_strobe = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verif/test_synth_config_register_bank.sv
// self-checking bench for the serial-loaded register bank
`timescale 1ns/1ps
`default_nettype none
module test_synth_config_register_bank;
    logic core_clk;
    logic sys_rst;
    wire logic serial_clk;
    wire logic serial_data;
    wire logic load_strobe;
    scb_pkg::scb_settings_s settings;
    logic [31:0] word_out [8];
    logic [31:0] ew [8];
    logic [31:0] blo;
    logic [31:0] bref;
    int mismatches;
    int tests_run;

    scb_bank uut (.core_clk(core_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe), .settings(settings), .word_out(word_out));
    scb_host host (.core_clk(core_clk), .serial_clk(serial_clk), .serial_data(serial_data),
        .load_strobe(load_strobe));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // expectations and checks
    // ----------------------------------------
    function automatic scb_pkg::scb_settings_s exp_settings();
        scb_pkg::scb_settings_s s;
        s.ramp_enable = ew[0][31];
        s.test_output_selector = ew[0][30:27];
        s.integer_value = ew[0][26:15];
        s.fine_divide_numerator = 25'(blo[27:15]) + (25'(ew[0][14:3]) << 13);
        s.slip_reduction_enable = ew[2][28];
        s.charge_pump_current = bref[27:24];
        s.reference_halving = bref[21];
        s.reference_doubler = bref[20];
        s.reference_count = bref[19:15];
        s.detector_sign_select = ew[3][6];
        return s;
    endfunction

    function automatic logic [31:0] rnd(input logic [2:0] sel);
        logic [31:0] r;
        r = $urandom;
        return {r[31:3], sel};
    endfunction

    // host side: reserved bits zero, slip reduction only in its legal setup
    function automatic logic [31:0] legal_word(input logic [31:0] w);
        logic [31:0] r;
        case (w[2:0])
            3'h1: r = w & 32'h0fff_8007;
            3'h2: r = w & 32'h1f7f_ffff;
            3'h3: r = w & 32'h0000_cfff;
            3'h4: r = w & 32'h807f_ff87;
            3'h5: r = w & 32'h3fff_ffff;
            3'h6: r = w & 32'h00ff_ffff;
            3'h7: r = w & 32'h0007_ffff;
            default: r = w;
        endcase
        if (r[2:0] == 3'h2 && r[28]) begin
            r[21] = 1'b1;
            r[27:24] = 4'h0;
            if (!ew[3][6]) begin
                r[28] = 1'b0;
            end
        end
        if (r[2:0] == 3'h3 && ew[2][28]) begin
            r[6] = 1'b1;
        end
        return r;
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic check_all();
        for (int k = 0; k < 8; k++) begin
            check($sformatf("word_out[%0d]", k), 64'(ew[k]), 64'(word_out[k]));
        end
        check("settings", 64'(exp_settings()), 64'(settings));
    endtask

    task automatic clear_exp();
        for (int k = 0; k < 8; k++) begin
            ew[k] = 32'h0000_0000;
        end
        blo = 32'h0000_0000;
        bref = 32'h0000_0000;
    endtask

    task automatic load(input logic [31:0] w);
        int n;
        logic [31:0] lw;
        lw = legal_word(w);
        host.send_word(lw);
        ew[lw[2:0]] = lw;
        if (lw[2:0] == 3'h0) begin
            blo = ew[1];
            bref = ew[2];
        end
        for (n = 0; n < 20 && word_out[lw[2:0]] !== lw; n++) begin
            @(negedge core_clk);
        end
        if (n == 20) begin
            mismatches++;
            conclude();
        end
        repeat (2) @(negedge core_clk);
        check_all();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1;
        mismatches = 0;
        tests_run = 0;
        clear_exp();
        void'($urandom(35501));
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        check_all();
        // buffered fields wait for the integer/fraction word
        load(rnd(3'h1));
        load(rnd(3'h2));
        load(rnd(3'h3) | 32'h0000_0040);
        load(rnd(3'h0));
        load(32'hffff_fff8);
        load(32'h0fff_8001);
        load(32'h1fff_fffa);
        load(32'h0000_0000);
        for (int k = 7; k >= 0; k--) begin
            load(rnd(3'(k)));
        end
        repeat (24) load($urandom);
        // reset in mid-run clears every latch
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        clear_exp();
        repeat (3) @(negedge core_clk);
        check_all();
        load(rnd(3'h2));
        load(rnd(3'h0));
        conclude();
    end
endmodule
`default_nettype wire
